// ===== core/ceeu_core_end.sv
// Summary of operation
// - status word: flags low half, mode high
// - debug entry sets debug bit, jumps
// - debug saves return address, status locally
// - mode bits freely writable in debug
// - debug return restores saved context
// - fetch starts at fixed reset address
// - miss and supervisor call fixed handlers
// - each exception has own entry offset
// - protection violation raises protection exception
// - no matching entry raises miss exception
// - multiple matches raise multiple-hit exception
// - interrupt branches to base plus offset
// - autovector offset is fourteen bits
// - software keeps offsets clear of code
// - software protects handlers before loading base
// - same-instruction events served by priority
// - oldest instruction's events served first
// - memory unit, coprocessor, float causes never
// - interrupt entry pushes scratch, return, status
// - exception return pops status and address
module ceeu_core_end (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // link to the interrupt controller
    ceeu_if.core             link,
    // pipeline events, index 0 = oldest (execute), 1 = decode
    input  wire logic [1:0]  fetchProt,
    input  wire logic [1:0]  fetchMatch0,
    input  wire logic [1:0]  fetchMulti,
    input  wire logic [1:0]  fetchAlign,
    input  wire logic [1:0]  dataValid,
    input  wire logic [1:0]  dataWrite,
    input  wire logic [1:0]  dataProt,
    input  wire logic [1:0]  dataMatch0,
    input  wire logic [1:0]  dataMulti,
    input  wire logic [1:0]  dataAlign,
    input  wire logic [1:0]  illegalOp,
    input  wire logic [1:0]  privOp,
    input  wire logic [1:0]  superCall,
    input  wire logic [31:0] instrPc,
    // debug and returns
    input  wire logic        debugReq,
    input  wire logic        debugReturn,
    input  wire logic        excReturn,
    input  wire logic [31:0] poppedPc,
    input  wire logic [31:0] poppedStatus,
    // status and base writes
    input  wire logic        statusWrite,
    input  wire logic [31:0] statusData,
    input  wire logic        baseWrite,
    input  wire logic [31:0] baseData,
    // outputs
    output logic [31:0]      fetchPc,
    output logic             redirect,
    output logic             flush,
    output logic [3:0]       causeCode,
    output logic [1:0]       stackOp,
    output logic [31:0]      stackPc,
    output logic [31:0]      stackStatus,
    output logic [31:0]      statusWord,
    output logic [31:0]      eventBase,
    output logic             irqAckOut
);
    logic [31:0]  status_reg;
    logic [31:0]  base_reg;
    logic [31:0]  dbgPc_reg;
    logic [31:0]  dbgStatus_reg;
    ceeu_pkg::ceeu_cause_t cause_next;
    logic [31:0]  offset_next;
    logic         inDebug;

    // ==========================================
    // classification helpers
    // picks highest priority cause of one instruction
    function automatic ceeu_pkg::ceeu_cause_t pick(input logic fp, fm0, fmu, fa,
            dv, dw, dp, dm0, dmu, da, il, pr, sc);
        ceeu_pkg::ceeu_cause_t c;
        c = ceeu_pkg::CE_NONE;
        if (fmu || (dv && dmu))    c = ceeu_pkg::CE_MULTI_HIT;
        else if (fa)               c = ceeu_pkg::CE_ADDR_FETCH;
        else if (fp)               c = ceeu_pkg::CE_PROT_FETCH;
        else if (fm0)              c = ceeu_pkg::CE_MISS_FETCH;
        else if (il)               c = ceeu_pkg::CE_ILLEGAL;
        else if (pr)               c = ceeu_pkg::CE_PRIVILEGE;
        else if (sc)               c = ceeu_pkg::CE_SUPER_CALL;
        else if (dv && da)         c = dw ? ceeu_pkg::CE_ADDR_WRITE : ceeu_pkg::CE_ADDR_READ;
        else if (dv && dp)         c = dw ? ceeu_pkg::CE_PROT_WRITE : ceeu_pkg::CE_PROT_READ;
        else if (dv && dm0)        c = dw ? ceeu_pkg::CE_MISS_WRITE : ceeu_pkg::CE_MISS_READ;
        return c;
    endfunction

    // handler offset per cause; no memory-unit, coprocessor or float causes
    function automatic logic [31:0] offsetOf(input ceeu_pkg::ceeu_cause_t c);
        case (c)
            ceeu_pkg::CE_MULTI_HIT:  offsetOf = ceeu_pkg::OFS_MULTI_HIT;
            ceeu_pkg::CE_ADDR_FETCH: offsetOf = ceeu_pkg::OFS_ADDR_FETCH;
            ceeu_pkg::CE_PROT_FETCH: offsetOf = ceeu_pkg::OFS_PROT_FETCH;
            ceeu_pkg::CE_MISS_FETCH: offsetOf = ceeu_pkg::OFS_MISS_FETCH;
            ceeu_pkg::CE_ILLEGAL:    offsetOf = ceeu_pkg::OFS_ILLEGAL;
            ceeu_pkg::CE_PRIVILEGE:  offsetOf = ceeu_pkg::OFS_PRIVILEGE;
            ceeu_pkg::CE_SUPER_CALL: offsetOf = ceeu_pkg::OFS_SUPER_CALL;
            ceeu_pkg::CE_ADDR_READ:  offsetOf = ceeu_pkg::OFS_ADDR_READ;
            ceeu_pkg::CE_ADDR_WRITE: offsetOf = ceeu_pkg::OFS_ADDR_WRITE;
            ceeu_pkg::CE_PROT_READ:  offsetOf = ceeu_pkg::OFS_PROT_READ;
            ceeu_pkg::CE_PROT_WRITE: offsetOf = ceeu_pkg::OFS_PROT_WRITE;
            ceeu_pkg::CE_MISS_READ:  offsetOf = ceeu_pkg::OFS_MISS_READ;
            ceeu_pkg::CE_MISS_WRITE: offsetOf = ceeu_pkg::OFS_MISS_WRITE;
            default:                 offsetOf = ceeu_pkg::OFS_UNRECOVER;
        endcase
    endfunction

    // ==========================================
    // event selection
    assign inDebug = status_reg[ceeu_pkg::DEBUG_BIT];

    // oldest instruction wins over any younger one
    always_comb begin
        ceeu_pkg::ceeu_cause_t c0;
        ceeu_pkg::ceeu_cause_t c1;
        c0 = pick(fetchProt[0], fetchMatch0[0], fetchMulti[0], fetchAlign[0], dataValid[0],
                  dataWrite[0], dataProt[0], dataMatch0[0], dataMulti[0], dataAlign[0],
                  illegalOp[0], privOp[0], superCall[0]);
        c1 = pick(fetchProt[1], fetchMatch0[1], fetchMulti[1], fetchAlign[1], dataValid[1],
                  dataWrite[1], dataProt[1], dataMatch0[1], dataMulti[1], dataAlign[1],
                  illegalOp[1], privOp[1], superCall[1]);
        cause_next = (c0 != ceeu_pkg::CE_NONE) ? c0 : c1;
        // interrupts only between instructions, masked by global mask bit
        if (cause_next == ceeu_pkg::CE_NONE && link.irqReq && !inDebug
                && !status_reg[ceeu_pkg::GLOBAL_MASK] && !irqAckOut) begin
            cause_next = ceeu_pkg::CE_INTERRUPT;
        end
        if (cause_next == ceeu_pkg::CE_INTERRUPT) begin
            offset_next = {18'h0, link.autoOffset};
        end else begin
            offset_next = offsetOf(cause_next);
        end
    end

    // ==========================================
    // event vector base
    always_ff @(posedge core_clk) begin
        if (rst) begin
            base_reg <= 32'h00000000;
        end else if (baseWrite) begin
            base_reg <= baseData;   // no check on where software points it
        end
    end

    // ==========================================
    // status word; low half flags+control, high half mode+state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_reg <= ceeu_pkg::STATUS_RESET;
        end else if (debugReq && !inDebug) begin
            status_reg[ceeu_pkg::DEBUG_BIT] <= 1'b1;
        end else if (debugReturn && inDebug) begin
            status_reg <= dbgStatus_reg;
        end else if (excReturn) begin
            status_reg <= poppedStatus;
        end else if (cause_next != ceeu_pkg::CE_NONE) begin
            status_reg[ceeu_pkg::GLOBAL_MASK] <= 1'b1; // mask nesting until return
        end else if (statusWrite) begin
            // in debug everything but the debug bit, mode bits included, is writable
            if (inDebug) begin
                status_reg <= statusData | (32'h00000001 << ceeu_pkg::DEBUG_BIT);
            end else begin
                status_reg[ceeu_pkg::HALF_WIDTH-1:0] <= statusData[ceeu_pkg::HALF_WIDTH-1:0];
                status_reg[ceeu_pkg::GLOBAL_MASK]    <= statusData[ceeu_pkg::GLOBAL_MASK];
            end
        end
    end

    // dedicated debug return registers, no stack traffic
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dbgPc_reg     <= 32'h00000000;
            dbgStatus_reg <= 32'h00000000;
        end else if (debugReq && !inDebug) begin
            dbgPc_reg     <= instrPc;
            dbgStatus_reg <= status_reg;
        end
    end

    // ==========================================
    // redirect, stack requests
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fetchPc     <= ceeu_pkg::RESET_ADDR;
            redirect    <= 1'b1;
            flush       <= 1'b0;
            causeCode   <= ceeu_pkg::CE_NONE;
            stackOp     <= ceeu_pkg::CE_STK_NONE;
            stackPc     <= 32'h00000000;
            stackStatus <= 32'h00000000;
            irqAckOut   <= 1'b0;
        end else begin
            redirect  <= 1'b0;
            flush     <= 1'b0;
            stackOp   <= ceeu_pkg::CE_STK_NONE;
            irqAckOut <= 1'b0;
            causeCode <= ceeu_pkg::CE_NONE;
            if (debugReq && !inDebug) begin
                fetchPc  <= ceeu_pkg::DEBUG_ENTRY;
                redirect <= 1'b1;
                flush    <= 1'b1;
            end else if (debugReturn && inDebug) begin
                fetchPc  <= dbgPc_reg;
                redirect <= 1'b1;
                flush    <= 1'b1;
            end else if (excReturn) begin
                fetchPc  <= poppedPc;
                redirect <= 1'b1;
                flush    <= 1'b1;
                stackOp  <= ceeu_pkg::CE_STK_POP;
            end else if (cause_next != ceeu_pkg::CE_NONE) begin
                fetchPc     <= base_reg + offset_next;
                redirect    <= 1'b1;
                flush       <= 1'b1;
                causeCode   <= cause_next;
                stackPc     <= instrPc;
                stackStatus <= status_reg;
                // scratch set pushed whatever the level
                stackOp <= (cause_next == ceeu_pkg::CE_INTERRUPT) ?
                           ceeu_pkg::CE_STK_PUSH_INT : ceeu_pkg::CE_STK_PUSH_EXC;
                irqAckOut <= (cause_next == ceeu_pkg::CE_INTERRUPT);
            end
        end
    end

    assign statusWord  = status_reg;
    assign eventBase   = base_reg;
    assign link.irqAck = irqAckOut;
endmodule

// ===== shared/ceeu_pkg.sv
package ceeu_pkg;
    // ==========================================
    // status word layout
    localparam int STATUS_WIDTH = 32;
    localparam int FLAG_CARRY   = 0;
    localparam int FLAG_ZERO    = 1;
    localparam int FLAG_NEG     = 2;
    localparam int FLAG_OVF     = 3;
    localparam int FLAG_SAT     = 4;
    localparam int CTRL_LOW     = 5;
    localparam int CTRL_HIGH    = 7;
    localparam int HALF_WIDTH   = 16;
    localparam int MODE_LOW     = 22;
    localparam int MODE_HIGH    = 24;
    localparam int DEBUG_BIT    = 27;
    localparam int GLOBAL_MASK  = 16;
    localparam logic [31:0] STATUS_RESET = 32'h00400000;

    // ==========================================
    // addresses and handler offsets
    localparam logic [31:0] RESET_ADDR      = 32'h80000000;
    localparam logic [31:0] DEBUG_ENTRY     = 32'h80000004;
    localparam int          AUTOVEC_WIDTH   = 14;
    localparam logic [31:0] OFS_UNRECOVER   = 32'h00000000;
    localparam logic [31:0] OFS_BUS_FETCH   = 32'h00000004;
    localparam logic [31:0] OFS_BUS_DATA    = 32'h00000008;
    localparam logic [31:0] OFS_MULTI_HIT   = 32'h00000010;
    localparam logic [31:0] OFS_ADDR_FETCH  = 32'h00000014;
    localparam logic [31:0] OFS_PROT_FETCH  = 32'h00000018;
    localparam logic [31:0] OFS_ILLEGAL     = 32'h00000020;
    localparam logic [31:0] OFS_PRIVILEGE   = 32'h00000028;
    localparam logic [31:0] OFS_ADDR_READ   = 32'h00000030;
    localparam logic [31:0] OFS_ADDR_WRITE  = 32'h00000034;
    localparam logic [31:0] OFS_PROT_READ   = 32'h00000038;
    localparam logic [31:0] OFS_PROT_WRITE  = 32'h0000003c;
    localparam logic [31:0] OFS_MISS_FETCH  = 32'h00000050;
    localparam logic [31:0] OFS_MISS_READ   = 32'h00000060;
    localparam logic [31:0] OFS_MISS_WRITE  = 32'h00000070;
    localparam logic [31:0] OFS_SUPER_CALL  = 32'h00000100;

    // ==========================================
    // event causes, index is priority (0 highest)
    typedef enum logic [3:0] {
        CE_MULTI_HIT, CE_ADDR_FETCH, CE_PROT_FETCH, CE_MISS_FETCH,
        CE_ILLEGAL, CE_PRIVILEGE, CE_SUPER_CALL, CE_ADDR_READ, CE_ADDR_WRITE,
        CE_PROT_READ, CE_PROT_WRITE, CE_MISS_READ, CE_MISS_WRITE,
        CE_INTERRUPT, CE_NONE
    } ceeu_cause_t;

    // ==========================================
    // what the stack engine is asked to do
    typedef enum logic [1:0] {
        CE_STK_NONE, CE_STK_PUSH_INT, CE_STK_PUSH_EXC, CE_STK_POP
    } ceeu_stack_t;
endpackage

// ===== shared/ceeu_if.sv
interface ceeu_if;
    // interrupt request and its autovector offset
    logic        irqReq;
    logic [ceeu_pkg::AUTOVEC_WIDTH-1:0] autoOffset;
    logic        irqAck;

    modport core (
        input  irqReq,
        input  autoOffset,
        output irqAck
    );
    modport ctrl (
        output irqReq,
        output autoOffset,
        input  irqAck
    );
endinterface

// ===== core/ceeu_intc_end.sv
module ceeu_intc_end (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // link to the core
    ceeu_if.ctrl             link,
    // user side
    input  wire logic        userReq,
    input  wire logic [13:0] userOffset,
    output logic             userDone
);
    logic        req_reg;
    logic [13:0] offset_reg;

    // hold the request and a stable offset until the core acks
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_reg    <= 1'b0;
            offset_reg <= 14'h0000;
        end else if (req_reg && link.irqAck) begin
            req_reg <= 1'b0;
        end else if (!req_reg && userReq) begin
            req_reg    <= 1'b1;
            offset_reg <= userOffset; // offset frozen while the request stands
        end
    end

    // one-cycle completion pulse
    always_ff @(posedge core_clk) begin
        if (rst) begin
            userDone <= 1'b0;
        end else begin
            userDone <= req_reg && link.irqAck;
        end
    end

    assign link.irqReq     = req_reg;
    assign link.autoOffset = offset_reg;
endmodule

// ===== test/ceeu_sva.sv
module ceeu_sva (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // interrupt link
    input wire logic        irqReq,
    input wire logic [13:0] autoOffset,
    input wire logic        irqAck,
    // core results
    input wire logic        redirect,
    input wire logic [31:0] fetchPc,
    input wire logic [3:0]  causeCode,
    input wire logic [1:0]  stackOp,
    input wire logic [31:0] statusWord,
    input wire logic [31:0] eventBase
);
    // ==========================================
    // one clock domain, so one default clock and reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_ack_pulse;
        irqAck |=> !irqAck;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    // ack only for a request seen while unmasked and outside debug
    property p_ack_cause;
        irqAck |-> $past(irqReq) && !$past(statusWord[ceeu_pkg::GLOBAL_MASK]) &&
            !$past(statusWord[ceeu_pkg::DEBUG_BIT]);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without legal request");
    property p_req_drop;
        irqAck |=> !irqReq;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("request held after ack");
    property p_off_stable;
        irqReq && $past(irqReq) |-> $stable(autoOffset);
    endproperty
    a_off_stable: assert property (p_off_stable) else $error("offset moved in request");
    property p_int_target;
        irqAck |-> redirect && fetchPc == eventBase + {18'h0, autoOffset};
    endproperty
    a_int_target: assert property (p_int_target) else $error("bad interrupt target");
    property p_int_push;
        irqAck |-> causeCode == ceeu_pkg::CE_INTERRUPT &&
            stackOp == ceeu_pkg::CE_STK_PUSH_INT && statusWord[ceeu_pkg::GLOBAL_MASK];
    endproperty
    a_int_push: assert property (p_int_push) else $error("interrupt entry incomplete");
    // the value seen at the first edge after release is the reset value
    property p_reset_pc;
        $fell(rst) |-> redirect && fetchPc == ceeu_pkg::RESET_ADDR;
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("no fetch from reset address");
    property p_debug_entry;
        $rose(statusWord[ceeu_pkg::DEBUG_BIT]) |-> redirect && fetchPc == ceeu_pkg::DEBUG_ENTRY &&
            stackOp == ceeu_pkg::CE_STK_NONE;
    endproperty
    a_debug_entry: assert property (p_debug_entry) else $error("debug entry wrong");
    property p_cause_legal;
        causeCode != ceeu_pkg::CE_NONE |-> redirect && causeCode < ceeu_pkg::CE_NONE;
    endproperty
    a_cause_legal: assert property (p_cause_legal) else $error("unused cause raised");
endmodule

// ===== test/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // design inputs and outputs
    logic        core_clk, rst, debugReq, debugReturn, excReturn, statusWrite, baseWrite, userReq;
    logic [1:0]  evIn [13];
    logic [31:0] instrPc, poppedPc, poppedStatus, statusData, baseData;
    logic [13:0] userOffset, off;
    logic [31:0] fetchPc, stackPc, stackStatus, statusWord, eventBase;
    logic [3:0]  causeCode;
    logic [1:0]  stackOp;
    logic        redirect, flush, irqAckOut, userDone;
    // bench model state
    logic [31:0] expBase, expStat, savedStat, ofsTab [14];
    logic [12:0] maskTab [14];
    int          failures, checksDone, cycles, a, b, w, pick [11];

    `define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin failures++; \
        $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

    // ==========================================
    // the two ends joined by the link
    ceeu_if lnk ();
    ceeu_intc_end i_ceeu_intc_end (.core_clk(core_clk), .rst(rst), .link(lnk),
        .userReq(userReq), .userOffset(userOffset), .userDone(userDone));
    ceeu_core_end i_ceeu_core_end (.core_clk(core_clk), .rst(rst), .link(lnk),
        .fetchProt(evIn[0]), .fetchMatch0(evIn[1]), .fetchMulti(evIn[2]), .fetchAlign(evIn[3]),
        .dataValid(evIn[4]), .dataWrite(evIn[5]), .dataProt(evIn[6]), .dataMatch0(evIn[7]),
        .dataMulti(evIn[8]), .dataAlign(evIn[9]), .illegalOp(evIn[10]), .privOp(evIn[11]),
        .superCall(evIn[12]), .instrPc(instrPc), .debugReq(debugReq),
        .debugReturn(debugReturn), .excReturn(excReturn), .poppedPc(poppedPc),
        .poppedStatus(poppedStatus), .statusWrite(statusWrite), .statusData(statusData),
        .baseWrite(baseWrite), .baseData(baseData), .fetchPc(fetchPc), .redirect(redirect),
        .flush(flush), .causeCode(causeCode), .stackOp(stackOp), .stackPc(stackPc),
        .stackStatus(stackStatus), .statusWord(statusWord), .eventBase(eventBase),
        .irqAckOut(irqAckOut));
    ceeu_sva u_sva (.core_clk(core_clk), .rst(rst), .irqReq(lnk.irqReq),
        .autoOffset(lnk.autoOffset), .irqAck(lnk.irqAck), .redirect(redirect),
        .fetchPc(fetchPc), .causeCode(causeCode), .stackOp(stackOp),
        .statusWord(statusWord), .eventBase(eventBase));

    // ==========================================
    // clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            finishTest();
        end
    end

    // ==========================================
    // helpers
    task automatic finishTest();
        if (failures == 0 && checksDone > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // inputs always move 5 ns after the edge
    task automatic tick();
        @(posedge core_clk);
        #5;
    endtask
    // one-cycle events, m0 on the oldest slot, m1 on the younger
    task automatic fire(input logic [12:0] m0, input logic [12:0] m1);
        tick(); // idle edge, so the lines are never set and cleared in one step
        instrPc = $urandom();
        for (int p = 0; p < 13; p++) evIn[p] = {m1[p], m0[p]};
        tick();
        for (int p = 0; p < 13; p++) evIn[p] = 2'b00;
    endtask
    task automatic wstat(input logic [31:0] d);
        statusData = d;
        statusWrite = 1'b1;
        tick();
        statusWrite = 1'b0;
    endtask
    // table case 13 is the data-side multiple hit
    function automatic int prio(input int k);
        return (k == 13) ? 0 : k;
    endfunction
    task automatic checkEvent(input int k);
        `CHK(causeCode, 4'(prio(k)))
        `CHK(fetchPc, expBase + ofsTab[k])
        `CHK(flush, 1'b1)
        `CHK(redirect, 1'b1)
        `CHK(stackPc, instrPc)
        `CHK(stackStatus, expStat)
        expStat = expStat | 32'h0001_0000;
        `CHK(statusWord, expStat)
    endtask

    // ==========================================
    // main sequence
    initial begin
        {rst, debugReq, debugReturn, excReturn, statusWrite, baseWrite, userReq} = 7'h40;
        for (int p = 0; p < 13; p++) evIn[p] = 2'b00;
        {instrPc, poppedPc, poppedStatus, statusData, baseData} = '0;
        userOffset = 14'h0;
        ofsTab = '{ceeu_pkg::OFS_MULTI_HIT, ceeu_pkg::OFS_ADDR_FETCH, ceeu_pkg::OFS_PROT_FETCH,
            ceeu_pkg::OFS_MISS_FETCH, ceeu_pkg::OFS_ILLEGAL, ceeu_pkg::OFS_PRIVILEGE,
            ceeu_pkg::OFS_SUPER_CALL, ceeu_pkg::OFS_ADDR_READ, ceeu_pkg::OFS_ADDR_WRITE,
            ceeu_pkg::OFS_PROT_READ, ceeu_pkg::OFS_PROT_WRITE, ceeu_pkg::OFS_MISS_READ,
            ceeu_pkg::OFS_MISS_WRITE, ceeu_pkg::OFS_MULTI_HIT};
        maskTab = '{13'h0004, 13'h0008, 13'h0001, 13'h0002, 13'h0400, 13'h0800, 13'h1000,
            13'h0210, 13'h0230, 13'h0050, 13'h0070, 13'h0090, 13'h00b0, 13'h0110};
        pick = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 11, 13};
        void'($urandom(16));
        repeat (16) @(posedge core_clk);
        #5;
        `CHK(fetchPc, ceeu_pkg::RESET_ADDR)
        `CHK(statusWord, ceeu_pkg::STATUS_RESET)
        rst = 1'b0;
        expStat = ceeu_pkg::STATUS_RESET;
        baseData = $urandom(); // taken as a pointer into protected flash
        expBase = baseData;
        baseWrite = 1'b1;
        tick();
        baseWrite = 1'b0;
        `CHK(eventBase, expBase)
        // every cause alone, then random pairs by priority and by age
        for (int k = 0; k < 14; k++) begin
            fire(maskTab[k], 13'h0);
            checkEvent(k);
        end
        for (int n = 0; n < 8; n++) begin
            a = pick[$urandom_range(10)];
            b = pick[$urandom_range(10)];
            fire(maskTab[a] | maskTab[b], 13'h0);
            checkEvent(prio(a) <= prio(b) ? a : b);
            fire(maskTab[b], maskTab[a]);
            checkEvent(b);
        end
        // return from exception restores a fully known status
        poppedPc = $urandom();
        poppedStatus = $urandom() & 32'hf7ff_ffff;
        excReturn = 1'b1;
        tick();
        excReturn = 1'b0;
        `CHK(fetchPc, poppedPc)
        `CHK(statusWord, poppedStatus)
        `CHK(stackOp, ceeu_pkg::CE_STK_POP)
        wstat($urandom());
        expStat = (poppedStatus & 32'hfffe_0000) | (statusData & 32'h0001_ffff);
        `CHK(statusWord, expStat)
        // debug entry, free write, return
        instrPc = $urandom();
        savedStat = expStat;
        debugReq = 1'b1;
        tick();
        debugReq = 1'b0;
        `CHK(fetchPc, ceeu_pkg::DEBUG_ENTRY)
        `CHK(statusWord[27], 1'b1)
        `CHK(stackOp, ceeu_pkg::CE_STK_NONE)
        wstat($urandom());
        `CHK(statusWord, statusData | 32'h0800_0000)
        debugReturn = 1'b1;
        tick();
        debugReturn = 1'b0;
        `CHK(fetchPc, instrPc)
        `CHK(statusWord, savedStat)
        // interrupts held off by the mask, then taken, widest offset first
        for (int n = 0; n < 3; n++) begin
            off = (n == 0) ? 14'h3fff : (14'($urandom()) | 14'h0200); // past handlers
            wstat(savedStat | 32'h0001_0000);
            userOffset = off;
            userReq = 1'b1;
            tick();
            userReq = 1'b0;
            repeat (6) tick();
            `CHK(irqAckOut, 1'b0)
            `CHK(lnk.irqReq, 1'b1)
            wstat(savedStat & 32'hfffe_ffff);
            for (w = 0; w < 12 && lnk.irqAck !== 1'b1; w++) tick();
            `CHK(lnk.irqAck, 1'b1)
            `CHK(fetchPc, expBase + {18'h0, off})
            `CHK(stackOp, ceeu_pkg::CE_STK_PUSH_INT)
            `CHK(causeCode, ceeu_pkg::CE_INTERRUPT)
            `CHK(redirect, 1'b1)
            `CHK(stackPc, instrPc)
            `CHK(stackStatus, savedStat & 32'hfffe_ffff)
            `CHK(statusWord, savedStat | 32'h0001_0000)
            tick();
            `CHK(userDone, 1'b1)
        end
        finishTest();
    end
endmodule
